// >>> drc_pkg.sv
// Constants and carrier types for the refresh and oscillator control block.
// Assumes a 125 MHz system clock.
package drc_pkg;
  localparam int unsigned DRC_CLK_HZ = 125000000;
  localparam int unsigned DRC_OSC_HZ = 21000;
  localparam int unsigned DRC_EXT_MAX_HZ = 200000;
  localparam int unsigned DRC_NUM_CHAN = 14;
  localparam int unsigned DRC_CODE_W = 8;
  // Half period of the internal oscillator, rounded down
  localparam logic [11:0] DRC_OSC_HALF_CYC = 12'(DRC_CLK_HZ / (2 * DRC_OSC_HZ));
  localparam logic [11:0] DRC_OSC_CNT_RST = 12'h000;
  localparam logic [3:0] DRC_CHAN_LAST = 4'(DRC_NUM_CHAN - 1);
  localparam logic [3:0] DRC_CHAN_RST = 4'h0;
  localparam logic [2:0] DRC_BIT_LAST = 3'h7;
  localparam logic [7:0] DRC_CODE_RST = 8'h00;
  localparam logic DRC_SEL_INTERNAL = 1'b0;
  localparam logic DRC_SEL_RST = DRC_SEL_INTERNAL;
  // Released pin idles high on its pull-up, so the edge detector starts there
  localparam logic DRC_PIN_IDLE = 1'b1;

  typedef struct packed {
    logic frame_start;
    logic bit_valid;
    logic bit_value;
  } drc_code_in_t;

  typedef struct packed {
    logic [3:0] chan;
    logic switch_closed;
    logic refresh_pulse;
  } drc_refresh_t;
endpackage

// >>> drc_pin_sync.sv
// Two-flop synchroniser with edge detect for the refresh clock pin input.
// Assumes the pin level is asynchronous to clk_sys.
`timescale 1ns/1ps
`default_nettype none
module drc_pin_sync
  import drc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic pin_in,
  output logic level,
  output logic rise,
  output logic fall
);
  logic meta;
  logic sync;
  logic prev;
  logic next_meta;
  logic next_sync;
  logic next_prev;

  always_comb begin
    next_meta = pin_in;
    next_sync = meta;
    next_prev = sync;
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      meta <= DRC_PIN_IDLE;
      sync <= DRC_PIN_IDLE;
      prev <= DRC_PIN_IDLE;
    end else begin
      meta <= next_meta;
      sync <= next_sync;
      prev <= next_prev;
    end
  end

  // Edges are seen only after both sync stages
  assign level = sync;
  assign rise = sync & ~prev;
  assign fall = ~sync & prev;
endmodule
`default_nettype wire

// >>> drc_refresh_ctrl.sv
// Refresh sequencer for 14 channel codes with internal/external refresh clock.
// Assumes code bits and control loads arrive synchronous to clk_sys.
// Functional notes
// - Channel codes are 8 bits, shifted in and assembled MSB first.
// - Falling refresh clock edge refreshes a channel output with its stored code.
// - Rising refresh clock edge opens the refresh switch, ending the interval.
// - Internal source gives about 21kHz clock, driven out on the pin.
// - Reset defaults to internal oscillator with the pin released.
// - External mode accepts another chip's internal clock on the pin.
// - Channels update in a continuous repeating cycle; latency depends on arrival.
// - Source select 0 picks internal clock and output pin; 1 external input.
// - External refresh clock up to about 200kHz is followed.
`timescale 1ns/1ps
`default_nettype none
module drc_refresh_ctrl
  import drc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire drc_code_in_t code_in,
  input wire logic ctrl_load,
  input wire logic osc_source_select,
  input wire logic refresh_clock_pin_in,
  output logic refresh_clock_pin_out,
  output logic refresh_clock_pin_oe_n,
  output logic [DRC_NUM_CHAN-1:0][DRC_CODE_W-1:0] channel_level,
  output drc_refresh_t refresh_state
);
  logic [7:0] shift;
  logic [2:0] bit_cnt;
  logic [3:0] wr_chan;
  logic [DRC_NUM_CHAN-1:0][DRC_CODE_W-1:0] code_store;
  logic sel;
  logic drive_en;
  logic [11:0] osc_cnt;
  logic osc_lvl;
  logic [3:0] rf_chan;
  logic sw_closed;
  logic rf_pulse;

  logic [7:0] next_shift;
  logic [2:0] next_bit_cnt;
  logic [3:0] next_wr_chan;
  logic [DRC_NUM_CHAN-1:0][DRC_CODE_W-1:0] next_code_store;
  logic next_sel;
  logic next_drive_en;
  logic [11:0] next_osc_cnt;
  logic next_osc_lvl;
  logic [3:0] next_rf_chan;
  logic next_sw_closed;
  logic next_rf_pulse;
  logic [DRC_NUM_CHAN-1:0][DRC_CODE_W-1:0] next_channel_level;
  logic next_pin_out;
  logic next_pin_oe_n;

  logic ext_level;
  logic ext_rise;
  logic ext_fall;
  logic osc_rise;
  logic osc_fall;
  logic clk_rise;
  logic clk_fall;

  // External clock path through the synchroniser
  drc_pin_sync u_pin_sync (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .pin_in(refresh_clock_pin_in),
    .level(ext_level),
    .rise(ext_rise),
    .fall(ext_fall)
  );

  // Serial code assembly
  // Bytes past the last channel are dropped until the next frame start
  always_comb begin
    next_shift = shift;
    next_bit_cnt = bit_cnt;
    next_wr_chan = wr_chan;
    next_code_store = code_store;
    if (code_in.frame_start) begin
      next_bit_cnt = 3'h0;
      next_wr_chan = DRC_CHAN_RST;
    end else if (code_in.bit_valid) begin
      next_shift = {shift[6:0], code_in.bit_value};
      next_bit_cnt = 3'(bit_cnt + 3'h1);
      if (bit_cnt == DRC_BIT_LAST) begin
        if (wr_chan <= DRC_CHAN_LAST) begin
          next_code_store[wr_chan] = {shift[6:0], code_in.bit_value};
          next_wr_chan = 4'(wr_chan + 4'h1);
        end
      end
    end
  end

  // Source select and pin drive; pin stays released until internal mode is loaded
  // Switching source may leave one spurious edge from the old clock
  always_comb begin
    next_sel = sel;
    next_drive_en = drive_en;
    if (ctrl_load) begin
      next_sel = osc_source_select;
      next_drive_en = (osc_source_select == DRC_SEL_INTERNAL);
    end
    next_pin_oe_n = ~(next_drive_en && next_sel == DRC_SEL_INTERNAL);
  end

  // Internal oscillator
  // Counter runs in both modes so the pin drives a clean level at a switch
  always_comb begin
    next_osc_cnt = 12'(osc_cnt + 12'h001);
    next_osc_lvl = osc_lvl;
    osc_rise = 1'b0;
    osc_fall = 1'b0;
    if (osc_cnt >= DRC_OSC_HALF_CYC - 12'h001) begin
      next_osc_cnt = DRC_OSC_CNT_RST;
      next_osc_lvl = ~osc_lvl;
      osc_rise = ~osc_lvl;
      osc_fall = osc_lvl;
    end
    next_pin_out = next_osc_lvl;
  end

  // Selected refresh clock edges
  always_comb begin
    if (sel == DRC_SEL_INTERNAL) begin
      clk_rise = osc_rise;
      clk_fall = osc_fall;
    end else begin
      clk_rise = ext_rise;
      clk_fall = ext_fall;
    end
  end

  // Continuous refresh cycle over all channels
  always_comb begin
    next_rf_chan = rf_chan;
    next_sw_closed = sw_closed;
    next_rf_pulse = 1'b0;
    next_channel_level = channel_level;
    if (clk_fall) begin
      next_channel_level[rf_chan] = code_store[rf_chan];
      next_sw_closed = 1'b1;
      next_rf_pulse = 1'b1;
    end else if (clk_rise && sw_closed) begin
      next_sw_closed = 1'b0;
      // A fall with the switch still closed refreshes the same channel again
      if (rf_chan == DRC_CHAN_LAST) begin
        next_rf_chan = DRC_CHAN_RST;
      end else begin
        next_rf_chan = 4'(rf_chan + 4'h1);
      end
    end
  end

  // Code assembly registers
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      shift <= DRC_CODE_RST;
      bit_cnt <= 3'h0;
      wr_chan <= DRC_CHAN_RST;
      code_store <= '0;
    end else begin
      shift <= next_shift;
      bit_cnt <= next_bit_cnt;
      wr_chan <= next_wr_chan;
      code_store <= next_code_store;
    end
  end

  // Source select registers
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      sel <= DRC_SEL_RST;
      drive_en <= 1'b0;
    end else begin
      sel <= next_sel;
      drive_en <= next_drive_en;
    end
  end

  // Oscillator registers
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      osc_cnt <= DRC_OSC_CNT_RST;
      osc_lvl <= 1'b0;
    end else begin
      osc_cnt <= next_osc_cnt;
      osc_lvl <= next_osc_lvl;
    end
  end

  // Refresh sequencing registers
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      rf_chan <= DRC_CHAN_RST;
      sw_closed <= 1'b0;
      rf_pulse <= 1'b0;
      channel_level <= '0;
    end else begin
      rf_chan <= next_rf_chan;
      sw_closed <= next_sw_closed;
      rf_pulse <= next_rf_pulse;
      channel_level <= next_channel_level;
    end
  end

  // Pin registers; released at reset to avoid contention
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      refresh_clock_pin_out <= 1'b0;
      refresh_clock_pin_oe_n <= 1'b1;
    end else begin
      refresh_clock_pin_out <= next_pin_out;
      refresh_clock_pin_oe_n <= next_pin_oe_n;
    end
  end

  assign refresh_state.chan = rf_chan;
  assign refresh_state.switch_closed = sw_closed;
  assign refresh_state.refresh_pulse = rf_pulse;
endmodule
`default_nettype wire

// >>> drc_clk_src.sv
// Partner: external refresh clock source at 200 kHz.
// Assumes the bench resolves the shared pin.
`timescale 1ns/1ps
`default_nettype none
module drc_clk_src (
  input wire logic run,
  output logic clk_out
);
  // Edges only on its own fixed schedule, away from load events
  initial clk_out = 1'b1;
  always begin
    wait (run);
    // 5000 ns period, edges kept off the system clock's rising edge
    #2501 clk_out = 1'b0;
    #2499 clk_out = 1'b1;
  end
endmodule
`default_nettype wire

// >>> drc_refresh_checker.sv
// Port checker for the refresh controller.
// Assumes bind onto drc_refresh_ctrl.
`timescale 1ns/1ps
`default_nettype none
module drc_refresh_checker
  import drc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ctrl_load,
  input wire logic osc_source_select,
  input wire logic refresh_clock_pin_in,
  input wire logic refresh_clock_pin_out,
  input wire logic refresh_clock_pin_oe_n,
  input wire logic [DRC_NUM_CHAN-1:0][DRC_CODE_W-1:0] channel_level,
  input wire drc_refresh_t refresh_state
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  logic ext, next_ext, prev;
  logic [11:0] run, next_run;
  // Stable-time of the driven oscillator level
  always_comb begin
    next_ext = ctrl_load ? osc_source_select : ext;
    next_run = (refresh_clock_pin_out == prev && !refresh_clock_pin_oe_n) ? run + 12'h1 : 12'h000;
  end
  always_ff @(posedge clk_sys) begin
    ext <= rstn ? next_ext : 1'b0;
    run <= rstn ? next_run : 12'h000;
    prev <= refresh_clock_pin_out;
  end
  AST_OE_LOAD: assert property (ctrl_load |=> refresh_clock_pin_oe_n == $past(osc_source_select))
    else $error("pin enable does not follow source select");
  AST_RST_REL: assert property ($rose(rstn) |-> refresh_clock_pin_oe_n && channel_level == '0)
    else $error("outputs not at reset state");
  AST_EXT_FALL: assert property (ext && $fell(refresh_clock_pin_in) && !refresh_state.switch_closed
    |-> ##[2:4] refresh_state.switch_closed)
    else $error("falling pin edge missed");
  AST_EXT_RISE: assert property (ext && $rose(refresh_clock_pin_in) && refresh_state.switch_closed
    |-> ##[2:4] !refresh_state.switch_closed)
    else $error("switch not opened");
  AST_PULSE: assert property ($rose(refresh_state.switch_closed) |-> refresh_state.refresh_pulse ##1
    !refresh_state.refresh_pulse)
    else $error("refresh pulse wrong");
  AST_LEVEL: assert property ($changed(channel_level) |-> $rose(refresh_state.switch_closed))
    else $error("level changed outside refresh");
  AST_CHAN: assert property ($changed(refresh_state.chan) |-> refresh_state.chan ==
    ($past(refresh_state.chan) == DRC_CHAN_LAST ? DRC_CHAN_RST : $past(refresh_state.chan) + 4'h1))
    else $error("channel order wrong");
  AST_OSC_RUN: assert property (!refresh_clock_pin_oe_n |-> run < DRC_OSC_HALF_CYC)
    else $error("oscillator half period too long");
  cover property (ext && $rose(refresh_state.switch_closed));
  cover property (!ext && refresh_state.refresh_pulse);
  cover property ($changed(refresh_state.chan) && refresh_state.chan == DRC_CHAN_RST);
endmodule
bind drc_refresh_ctrl drc_refresh_checker u_drc_refresh_checker (.clk_sys, .rstn, .ctrl_load,
  .osc_source_select, .refresh_clock_pin_in, .refresh_clock_pin_out, .refresh_clock_pin_oe_n,
  .channel_level, .refresh_state);
`default_nettype wire

// >>> tb_drc_refresh_ctrl.sv
// Testbench for the refresh controller.
// Assumes the checker is bound in.
`timescale 1ns/1ps
`default_nettype none
module tb_drc_refresh_ctrl;
  import drc_pkg::*;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  drc_code_in_t code_in = '0;
  logic ctrl_load = 1'b0;
  logic sel = 1'b0;
  logic run = 1'b0;
  logic src, pout, oe_n;
  wire logic pin;
  logic [DRC_NUM_CHAN-1:0][DRC_CODE_W-1:0] lvl;
  drc_refresh_t rs;
  logic [7:0] codes [DRC_NUM_CHAN];
  int fails = 0;
  int comparisons = 0;
  always #4 clk_sys = ~clk_sys;
  // Pulled high when nobody drives
  assign pin = !oe_n ? pout : (run ? src : 1'b1);
  drc_clk_src u_drc_clk_src (.run(run), .clk_out(src));
  drc_refresh_ctrl u_drc_refresh_ctrl (.clk_sys(clk_sys), .rstn(rstn), .code_in(code_in),
    .ctrl_load(ctrl_load), .osc_source_select(sel), .refresh_clock_pin_in(pin),
    .refresh_clock_pin_out(pout), .refresh_clock_pin_oe_n(oe_n), .channel_level(lvl), .refresh_state(rs));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wait_pulses(input int n);
    int k = 0;
    for (int i = 0; i < 20000 && k < n; i++) begin
      @(negedge clk_sys);
      if (rs.refresh_pulse === 1'b1) k++;
    end
    if (k < n) begin
      fails++;
      conclude();
    end
  endtask
  task automatic flip(output int n);
    logic p = pout;
    for (n = 0; n < 4000 && pout === p; n++) @(negedge clk_sys);
    if (n >= 4000) begin
      fails++;
      conclude();
    end
  endtask
  task automatic load(input logic s);
    sel = s;
    ctrl_load = 1'b1;
    @(negedge clk_sys);
    ctrl_load = 1'b0;
    @(negedge clk_sys);
  endtask
  task automatic t_reset();
    check(oe_n, 1'b1);
    check(lvl[0], 8'h00);
    $display("reset test done");
  endtask
  task automatic t_external();
    load(1'b1);
    check(oe_n, 1'b1);
    run = 1'b1;
    code_in = 3'b100;
    @(negedge clk_sys);
    // One extra byte, inverted, must be ignored
    for (int b = 0; b < (DRC_NUM_CHAN + 1) * 8; b++) begin
      code_in = {2'b01, codes[(b / 8) % DRC_NUM_CHAN][7 - b % 8] ^ (b >= DRC_NUM_CHAN * 8)};
      @(negedge clk_sys);
    end
    code_in = '0;
    wait_pulses(15);
    for (int i = 0; i < DRC_NUM_CHAN; i++) check(lvl[i], codes[i]);
    check(rs.chan, 4'h0);
    check(rs.switch_closed, 1'b1);
    $display("external test done");
  endtask
  task automatic t_internal();
    int n;
    load(1'b0);
    check(oe_n, 1'b0);
    run = 1'b0;
    flip(n);
    flip(n);
    check(n, DRC_OSC_HALF_CYC);
    wait_pulses(1);
    $display("internal test done");
  endtask
  initial begin
    for (int i = 0; i < DRC_NUM_CHAN; i++) codes[i] = 8'(i * 37 + 1);
    repeat (6) @(negedge clk_sys);
    rstn = 1'b1;
    t_reset();
    t_external();
    t_internal();
    conclude();
  end
endmodule
`default_nettype wire
